/* common/iofe_pkg.sv */
/*
  Constants shared by the flush command executor: command field layout,
  granularity codes, invalidation targets, match kinds and the register map.
  Assumes 128-bit commands arrive from the invalidation queue fetch unit.
*/
package iofe_pkg;
  // Command type codes, bits 3:0 of every command.
  localparam logic [3:0] TYPE_SL_FLUSH = 4'h2;
  localparam logic [3:0] TYPE_EXT_FLUSH = 4'h6;
  localparam int TYPE_LO = 0;
  localparam int TYPE_HI = 3;
  // Field positions inside the 128-bit command.
  localparam int GRAN_LO = 4;
  localparam int GRAN_HI = 5;
  localparam int WR_DRAIN_BIT = 6;
  localparam int RD_DRAIN_BIT = 7;
  localparam int DOM_LO = 16;
  localparam int DOM_HI = 31;
  localparam int PASID_LO = 32;
  localparam int PASID_HI = 51;
  localparam int HIGH_LO = 64;
  localparam int HIGH_HI = 127;
  localparam int MASK_LO = 64;
  localparam int MASK_HI = 69;
  localparam int KEEP_BIT = 70;
  localparam int SHARED_BIT = 71;
  localparam int PAGE_LO = 12;
  localparam int DOM_W = 16;
  localparam int PASID_W = 20;
  localparam int PAGE_W = 52;
  localparam int MASK_W = 6;
  // Granularity codes of the second-level flush.
  localparam logic [1:0] SL_GLOBAL = 2'h1;
  localparam logic [1:0] SL_DOMAIN = 2'h2;
  localparam logic [1:0] SL_PAGE = 2'h3;
  // Granularity codes of the extended flush.
  localparam logic [1:0] EXT_ALL = 2'h0;
  localparam logic [1:0] EXT_NONGLB = 2'h1;
  localparam logic [1:0] EXT_PASID = 2'h2;
  localparam logic [1:0] EXT_PAGE = 2'h3;
  // Invalidation target bits.
  localparam int TGT_W = 5;
  localparam int TGT_IOTLB_SL = 0;
  localparam int TGT_IOTLB_FL = 1;
  localparam int TGT_PSC_SL = 2;
  localparam int TGT_PSC_FL = 3;
  localparam int TGT_PASIDC = 4;
  localparam logic [TGT_W-1:0] TGT_NONE = 5'h00;
  localparam logic [TGT_W-1:0] TGT_ALL = 5'h1f;
  typedef enum logic [2:0] {
    MATCH_ALL,
    MATCH_DOM,
    MATCH_DOM_PASID,
    MATCH_DOM_RANGE,
    MATCH_PASID_RANGE
  } iofe_match_t;
  // Register map, byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_ERR = 8'h08;
  localparam logic [7:0] REG_CNT = 8'h0c;
  localparam int CFG_W = 24;
  localparam logic [CFG_W-1:0] CFG_MASK = 24'h017f1f;
  localparam logic [CFG_W-1:0] CFG_RESET = 24'h00_3010;
  localparam int CFG_DOMW_LO = 0;
  localparam int CFG_DOMW_HI = 4;
  localparam int CFG_MAX_GUEST_ADDR_WIDTH_LO = 8;
  localparam int CFG_MAX_GUEST_ADDR_WIDTH_HI = 14;
  localparam int CFG_PWF_BIT = 16;
  localparam int ERR_TYPE_BIT = 0;
  localparam int ERR_GRAN_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : iofe_pkg

/* rtl/iofe_flush_exec.sv */
/*
  Flush command executor: decodes second-level and extended IOTLB flush
  commands into invalidation operations, write buffer flush and drains.
  Assumes the fetch unit, caches and fabric answer with valid/ready or
  done pulses synchronous to clock.
*/
// Local design decisions: register access over AXI4-Lite and the register offsets.
// Contract
// - 128-bit command, type in bits 3:0.
// - Global code flushes every cache entry.
// - Domain code flushes all domain-tagged entries.
// - Page code: range second-level, whole-domain others.
// - Keep hint decides second-level structure flush.
// - Coarser invalidation allowed, never narrower.
// - Read drain flag drains queued reads.
// - Write drain flag drains queued writes.
// - Mask domain tag to width; ignore globally.
// - Mask address to guest width; ignore if coarse.
// - Posted write flush precedes second-level flush.
// - Extended all: domain entries including global pages.
// - Extended non-global across all address spaces.
// - Extended non-global within one address space.
// - Extended page: shared hint selects global pages.
// - Extended page keep hint decides structure flush.
// - Extended coarse codes ignore space and address.
// - Hints ignored except page codes.
// - Extended flush skips address-space cache entries.
// - Extended flush always drains reads and writes.
`timescale 1ns/1ps
`default_nettype none
module iofe_flush_exec
  import iofe_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Command from the invalidation queue fetch unit
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [127:0] cmd_data,
  output logic cmd_err,
  // Write buffer flush handshake
  output logic wbf_req,
  input wire logic wbf_done,
  // Invalidation operation to the translation caches
  output logic inv_valid,
  input wire logic inv_ready,
  output logic [TGT_W-1:0] inv_tgt,
  output iofe_match_t inv_match,
  output logic inv_glob,
  output logic [DOM_W-1:0] inv_domain,
  output logic [PASID_W-1:0] inv_pasid,
  output logic [PAGE_W-1:0] inv_page,
  output logic [MASK_W-1:0] inv_span,
  // Drains, read by the wait command logic
  output logic rd_drain_req,
  input wire logic rd_drain_done,
  output logic wr_drain_req,
  input wire logic wr_drain_done,
  output logic drains_clear,
  // AXI4-Lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);

  typedef enum logic [1:0] {ST_IDLE, ST_WBF, ST_OP0, ST_OP1} iofe_state_t;

  // Ones in the n lowest bits; n of 64 or more gives all ones.
  function automatic logic [63:0] low_ones(input logic [6:0] n);
    low_ones = ~({64{1'b1}} << n);
  endfunction : low_ones

  iofe_state_t state_ff;
  logic [CFG_W-1:0] cfg_ff;
  logic [1:0] err_ff;
  logic [31:0] cnt_ff;
  logic rd_pend_ff, wr_pend_ff;
  logic err_pulse_ff;
  logic [TGT_W-1:0] tgt_ff, tgt1_ff;
  iofe_match_t match_ff, match1_ff;
  logic glob_ff, glob1_ff, two_ops_ff;
  logic [DOM_W-1:0] dom_ff;
  logic [PASID_W-1:0] pasid_ff;
  logic [PAGE_W-1:0] page_ff, page1_ff;
  logic [MASK_W-1:0] span_ff, span1_ff;

  logic take;
  logic [3:0] c_type;
  logic [1:0] c_gran;
  logic c_keep, c_shared;
  logic [DOM_W-1:0] c_dom;
  logic [63:0] dom_ones;
  logic [63:0] c_high;
  logic bad_type, bad_gran, is_sl, need_rd, need_wr;
  logic [TGT_W-1:0] nxt_tgt0, nxt_tgt1;
  iofe_match_t nxt_match0, nxt_match1;
  logic nxt_glob0, nxt_glob1, nxt_two;
  logic [DOM_W-1:0] nxt_dom;
  logic [PASID_W-1:0] nxt_pasid;
  logic [PAGE_W-1:0] nxt_page;
  logic [MASK_W-1:0] nxt_span;

  assign cmd_ready = (state_ff == ST_IDLE);
  assign take = cmd_valid && cmd_ready;
  // type code sits in the lowest four bits.
  assign c_type = cmd_data[TYPE_HI:TYPE_LO];
  assign c_gran = cmd_data[GRAN_HI:GRAN_LO];
  assign c_keep = cmd_data[KEEP_BIT];
  assign c_shared = cmd_data[SHARED_BIT];
  // domain tag bits above the configured width are dropped.
  assign dom_ones = low_ones({2'h0, cfg_ff[CFG_DOMW_HI:CFG_DOMW_LO]});
  assign c_dom = cmd_data[DOM_HI:DOM_LO] & dom_ones[DOM_W-1:0];
  // address bits above the guest address width are dropped.
  assign c_high = cmd_data[HIGH_HI:HIGH_LO] &
                  low_ones(cfg_ff[CFG_MAX_GUEST_ADDR_WIDTH_HI:CFG_MAX_GUEST_ADDR_WIDTH_LO]);
  assign is_sl = (c_type == TYPE_SL_FLUSH);

  // Decode a command into at most two invalidation operations.
  always_comb
  begin
    bad_type = 1'b0;
    bad_gran = 1'b0;
    need_rd = 1'b0;
    need_wr = 1'b0;
    nxt_tgt0 = TGT_NONE;
    nxt_tgt1 = TGT_NONE;
    nxt_match0 = MATCH_ALL;
    nxt_match1 = MATCH_ALL;
    nxt_glob0 = 1'b1;
    nxt_glob1 = 1'b1;
    nxt_two = 1'b0;
    nxt_dom = c_dom;
    nxt_pasid = cmd_data[PASID_HI:PASID_LO];
    nxt_page = c_high[63:PAGE_LO];
    nxt_span = cmd_data[MASK_HI:MASK_LO];
    if (is_sl)
    begin
      // read drain requested by its flag.
      need_rd = cmd_data[RD_DRAIN_BIT];
      // write drain requested by its flag.
      need_wr = cmd_data[WR_DRAIN_BIT];
      nxt_pasid = '0;
      case (c_gran)
        SL_GLOBAL:
        begin
          nxt_tgt0 = TGT_ALL;
          // domain tag unused for global flush.
          nxt_dom = '0;
        end
        SL_DOMAIN:
        begin
          // every structure, entries of the domain.
          nxt_tgt0 = TGT_ALL;
          nxt_match0 = MATCH_DOM;
        end
        SL_PAGE:
        begin
          nxt_tgt0[TGT_IOTLB_SL] = 1'b1;
          nxt_tgt0[TGT_PSC_SL] = ~c_keep;
          nxt_match0 = MATCH_DOM_RANGE;
          nxt_tgt1[TGT_IOTLB_FL] = 1'b1;
          nxt_tgt1[TGT_PSC_FL] = 1'b1;
          nxt_tgt1[TGT_PASIDC] = 1'b1;
          nxt_match1 = MATCH_DOM;
          nxt_two = 1'b1;
        end
        default:
        begin
          // code 00b is undefined for this command.
          bad_gran = 1'b1;
        end
      endcase
    end
    else if (c_type == TYPE_EXT_FLUSH)
    begin
      // extended flushes always drain both directions.
      need_rd = 1'b1;
      need_wr = 1'b1;
      // address-space cache and second-level structures untouched.
      nxt_tgt0[TGT_IOTLB_FL] = 1'b1;
      nxt_tgt0[TGT_PSC_FL] = 1'b1;
      case (c_gran)
        EXT_ALL:
        begin
          // global pages included whatever the shared hint.
          nxt_match0 = MATCH_DOM;
        end
        EXT_NONGLB:
        begin
          // non-global pages of the domain, all spaces.
          nxt_match0 = MATCH_DOM;
          nxt_glob0 = 1'b0;
        end
        EXT_PASID:
        begin
          // non-global pages of one space and domain.
          nxt_match0 = MATCH_DOM_PASID;
          nxt_glob0 = 1'b0;
        end
        default:
        begin
          // shared hint selects global pages in the range.
          nxt_tgt0 = TGT_NONE;
          nxt_tgt0[TGT_IOTLB_FL] = 1'b1;
          nxt_match0 = MATCH_PASID_RANGE;
          nxt_glob0 = c_shared;
          nxt_tgt1[TGT_PSC_FL] = ~c_keep;
          nxt_match1 = MATCH_PASID_RANGE;
          nxt_two = ~c_keep;
        end
      endcase
      // coarse codes ignore the space and the address.
      if ((c_gran == EXT_ALL) || (c_gran == EXT_NONGLB))
      begin
        nxt_pasid = '0;
      end
    end
    else
    begin
      bad_type = 1'b1;
    end
    // address, hints and span unused unless page selective.
    // hints only act for the page codes handled above.
    if (c_gran != SL_PAGE)
    begin
      nxt_page = '0;
      nxt_span = '0;
    end
  end

  // Sequencer; a rejected command is consumed without any operation or drain.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= ST_IDLE;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (take && !bad_type && !bad_gran)
          begin
            // posted writes are flushed before the first op.
            if (is_sl && cfg_ff[CFG_PWF_BIT])
            begin
              state_ff <= ST_WBF;
            end
            else
            begin
              state_ff <= ST_OP0;
            end
          end
        end
        ST_WBF:
        begin
          if (wbf_done)
          begin
            state_ff <= ST_OP0;
          end
        end
        ST_OP0:
        begin
          if (inv_ready)
          begin
            state_ff <= two_ops_ff ? ST_OP1 : ST_IDLE;
          end
        end
        default:
        begin
          if (inv_ready)
          begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ops never narrower than decoded; they are issued as held.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tgt_ff <= TGT_NONE;
      tgt1_ff <= TGT_NONE;
      match_ff <= MATCH_ALL;
      match1_ff <= MATCH_ALL;
      glob_ff <= 1'b0;
      glob1_ff <= 1'b0;
      two_ops_ff <= 1'b0;
      dom_ff <= '0;
      pasid_ff <= '0;
      page_ff <= '0;
      page1_ff <= '0;
      span_ff <= '0;
      span1_ff <= '0;
    end
    else if (take && !bad_type && !bad_gran)
    begin
      tgt_ff <= nxt_tgt0;
      tgt1_ff <= nxt_tgt1;
      match_ff <= nxt_match0;
      match1_ff <= nxt_match1;
      glob_ff <= nxt_glob0;
      glob1_ff <= nxt_glob1;
      two_ops_ff <= nxt_two;
      dom_ff <= nxt_dom;
      pasid_ff <= nxt_pasid;
      page_ff <= nxt_page;
      span_ff <= nxt_span;
      // A whole-domain second op carries no range.
      page1_ff <= (nxt_match1 == MATCH_DOM) ? '0 : nxt_page;
      span1_ff <= (nxt_match1 == MATCH_DOM) ? '0 : nxt_span;
    end
    else if ((state_ff == ST_OP0) && inv_ready)
    begin
      tgt_ff <= tgt1_ff;
      match_ff <= match1_ff;
      glob_ff <= glob1_ff;
      page_ff <= page1_ff;
      span_ff <= span1_ff;
    end
  end

  assign wbf_req = (state_ff == ST_WBF);
  assign inv_valid = (state_ff == ST_OP0) || (state_ff == ST_OP1);
  assign inv_tgt = tgt_ff;
  assign inv_match = match_ff;
  assign inv_glob = glob_ff;
  assign inv_domain = dom_ff;
  assign inv_pasid = pasid_ff;
  assign inv_page = page_ff;
  assign inv_span = span_ff;

  // Pending drains; a new request wins over a done in the same cycle.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_pend_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
    end
    else
    begin
      // read drain outstanding until the fabric reports done.
      if (take && !bad_type && !bad_gran && need_rd)
      begin
        rd_pend_ff <= 1'b1;
      end
      else if (rd_drain_done)
      begin
        rd_pend_ff <= 1'b0;
      end
      // write drain outstanding until the fabric reports done.
      if (take && !bad_type && !bad_gran && need_wr)
      begin
        wr_pend_ff <= 1'b1;
      end
      else if (wr_drain_done)
      begin
        wr_pend_ff <= 1'b0;
      end
    end
  end

  assign rd_drain_req = rd_pend_ff;
  assign wr_drain_req = wr_pend_ff;
  // wait logic may complete only once drains and ops are done.
  assign drains_clear = !rd_pend_ff && !wr_pend_ff && (state_ff == ST_IDLE);

  // Error pulse and completed flush counter.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      err_pulse_ff <= 1'b0;
      cnt_ff <= '0;
    end
    else
    begin
      // one-cycle error pulse for a rejected command.
      err_pulse_ff <= take && (bad_type || bad_gran);
      if (inv_valid && inv_ready && !((state_ff == ST_OP0) && two_ops_ff))
      begin
        cnt_ff <= cnt_ff + 32'h0000_0001;
      end
    end
  end
  assign cmd_err = err_pulse_ff;

  // AXI4-Lite write channel.
  logic aw_got_ff, w_got_ff, bvalid_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff;
  logic do_wr;
  logic [1:0] err_clr, err_set;

  assign s_awready = !aw_got_ff && !bvalid_ff;
  assign s_wready = !w_got_ff && !bvalid_ff;
  assign do_wr = aw_got_ff && w_got_ff && !bvalid_ff;
  assign err_clr = (do_wr && (awaddr_ff == REG_ERR) && wstrb_ff[0]) ?
                   wdata_ff[1:0] : 2'h0;
  assign err_set = {take && bad_gran, take && bad_type};

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      bresp_ff <= RESP_OKAY;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_awaddr;
      end
      if (s_wvalid && s_wready)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_wdata;
        wstrb_ff <= s_wstrb;
      end
      if (do_wr)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        if ((awaddr_ff == REG_CFG) || (awaddr_ff == REG_ERR) ||
            (awaddr_ff == REG_STAT) || (awaddr_ff == REG_CNT))
        begin
          bresp_ff <= RESP_OKAY;
        end
        else
        begin
          bresp_ff <= RESP_SLVERR;
        end
      end
      else if (bvalid_ff && s_bready)
      begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign s_bvalid = bvalid_ff;
  assign s_bresp = bresp_ff;

  // Configuration register by byte lanes; error flags set over clear.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_ff <= CFG_RESET;
      err_ff <= '0;
    end
    else
    begin
      if (do_wr && (awaddr_ff == REG_CFG))
      begin
        for (int b = 0; b < CFG_W / 8; b++)
        begin
          if (wstrb_ff[b])
          begin
            cfg_ff[b*8 +: 8] <= wdata_ff[b*8 +: 8] & CFG_MASK[b*8 +: 8];
          end
        end
      end
      err_ff <= (err_ff & ~err_clr) | err_set;
    end
  end

  // AXI4-Lite read channel.
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  assign s_arready = !rvalid_ff;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end
    else if (s_arvalid && s_arready)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff <= RESP_OKAY;
      if (s_araddr == REG_CFG)
      begin
        rdata_ff <= {8'h00, cfg_ff};
      end
      else if (s_araddr == REG_STAT)
      begin
        rdata_ff <= {27'h0, drains_clear, wbf_req, wr_pend_ff, rd_pend_ff,
                     (state_ff != ST_IDLE)};
      end
      else if (s_araddr == REG_ERR)
      begin
        rdata_ff <= {30'h0, err_ff};
      end
      else if (s_araddr == REG_CNT)
      begin
        rdata_ff <= cnt_ff;
      end
      else
      begin
        rdata_ff <= '0;
        rresp_ff <= RESP_SLVERR;
      end
    end
    else if (rvalid_ff && s_rready)
    begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_rvalid = rvalid_ff;
  assign s_rdata = rdata_ff;
  assign s_rresp = rresp_ff;

endmodule : iofe_flush_exec
`default_nettype wire

/* verification/iofe_far_model.sv */
/*
  Far side model: caches, write buffer and drain logic.
  Answers at once, or after three cycles while slow is high.
*/
`timescale 1ns/1ps
`default_nettype none
module iofe_far_model (
  // Clock, reset and pacing
  input wire logic clock,
  input wire logic arst_n,
  input wire logic slow,
  // Requests
  input wire logic inv_valid,
  input wire logic wbf_req,
  input wire logic rd_drain_req,
  input wire logic wr_drain_req,
  // Answers
  output logic inv_ready,
  output logic wbf_done,
  output logic rd_drain_done,
  output logic wr_drain_done
);
  logic [1:0] wait_ff;
  logic go;
  logic any;
  assign go = !slow || wait_ff == 2'h3;
  assign any = inv_valid || wbf_req || rd_drain_req || wr_drain_req;
  assign inv_ready = inv_valid && go;
  assign wbf_done = wbf_req && go;
  assign rd_drain_done = rd_drain_req && go;
  assign wr_drain_done = wr_drain_req && go;
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      wait_ff <= 2'h0;
    else if (any && go)
      wait_ff <= 2'h0;
    else if (any)
      wait_ff <= wait_ff + 2'h1;
  end
endmodule : iofe_far_model
`default_nettype wire

/* verification/iofe_flush_exec_asserts.sv */
/*
  Port checker for the flush executor.
  Assumes it is bound to the executor top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module iofe_flush_exec_asserts
  import iofe_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Command
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [127:0] cmd_data,
  input wire logic cmd_err,
  // Operations and drains
  input wire logic wbf_req,
  input wire logic wbf_done,
  input wire logic inv_valid,
  input wire logic inv_ready,
  input wire logic [TGT_W-1:0] inv_tgt,
  input wire iofe_match_t inv_match,
  input wire logic inv_glob,
  input wire logic [DOM_W-1:0] inv_domain,
  input wire logic rd_drain_req,
  input wire logic wr_drain_req,
  input wire logic drains_clear
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  wire logic acc = cmd_valid && cmd_ready;
  wire logic sl = acc && cmd_data[3:0] == TYPE_SL_FLUSH;
  wire logic ext = acc && cmd_data[3:0] == TYPE_EXT_FLUSH;
  wire logic [1:0] gr = cmd_data[5:4];

  AST_ERR_PULSE:
    assert property (cmd_err && !acc |=> !cmd_err)
    else $error("error pulse too long");
  AST_BAD_CMD:
    assert property (acc && !sl && !ext |=> cmd_err && cmd_ready)
    else $error("undefined type not flagged");
  AST_SL_ALL:
    assert property (sl && gr == SL_GLOBAL |=> wbf_req || inv_valid &&
      inv_tgt == TGT_ALL && inv_glob && inv_domain == '0)
    else $error("global flush too narrow");
  AST_SL_DOM:
    assert property (sl && gr == SL_DOMAIN |=> wbf_req || inv_valid &&
      inv_tgt == TGT_ALL && inv_match == MATCH_DOM)
    else $error("domain flush wrong");
  AST_WBF_FIRST:
    assert property (wbf_req && !wbf_done |=> wbf_req && !inv_valid &&
      !cmd_ready)
    else $error("operation before buffer flush");
  AST_EXT_ALL:
    assert property (ext && gr == EXT_ALL |=> inv_valid &&
      inv_tgt == 5'h0a && inv_glob)
    else $error("extended all flush wrong");
  AST_EXT_DRAIN:
    assert property (ext |=> rd_drain_req && wr_drain_req)
    else $error("extended flush without drains");
  AST_OP_HOLD:
    assert property (inv_valid && !inv_ready |=> inv_valid &&
      $stable(inv_tgt) && $stable(inv_domain))
    else $error("operation changed before taken");
  AST_DRAIN_DONE:
    assert property (drains_clear |-> !rd_drain_req && !wr_drain_req &&
      cmd_ready)
    else $error("clear while drains pending");
endmodule : iofe_flush_exec_asserts
`default_nettype wire

/* verification/testbench.sv */
/*
  Bench for the flush executor: register and command tasks.
  Assumes the far side model answers every request.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
  begin \
    compares++; \
    if ((a) !== (b)) \
    begin \
      failures++; \
      $display("[FAIL] %0t got %h want %h", $time, a, b); \
    end \
  end
module testbench;
  import iofe_pkg::*;
  localparam logic [63:0] HI0 = 64'hffff_abcd_ef01_2009;
  localparam logic [63:0] HI1 = 64'hffff_abcd_ef01_2049;
  localparam logic [63:0] HI3 = 64'hffff_abcd_ef01_20c9;
  localparam logic [51:0] PG = 52'h0000abcdef012;
  localparam logic [15:0] D = 16'h0034;
  localparam logic [19:0] P = 20'habcde;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic slow = 1'b0;
  logic cmd_valid = 1'b0;
  logic [127:0] cmd_data = '0;
  logic cmd_ready, cmd_err, wbf_req, wbf_done, inv_valid, inv_ready;
  logic rd_drain_req, rd_drain_done, wr_drain_req, wr_drain_done;
  logic drains_clear, inv_glob;
  logic [TGT_W-1:0] inv_tgt;
  iofe_match_t inv_match;
  logic [DOM_W-1:0] inv_domain;
  logic [PASID_W-1:0] inv_pasid;
  logic [PAGE_W-1:0] inv_page;
  logic [MASK_W-1:0] inv_span;
  logic [7:0] s_awaddr = '0;
  logic [7:0] s_araddr = '0;
  logic [31:0] s_wdata = '0;
  logic [3:0] s_wstrb = 4'hf;
  logic s_awvalid = 1'b0;
  logic s_wvalid = 1'b0;
  logic s_bready = 1'b0;
  logic s_arvalid = 1'b0;
  logic s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata;
  int failures = 0;
  int compares = 0;
  logic [102:0] q[$];

  iofe_flush_exec dut_u (.*);
  iofe_far_model far_u (.*);

  always #4 clock = ~clock;

  always @(negedge clock)
    if (inv_valid && inv_ready)
      q.push_back({inv_tgt, inv_match, inv_glob, inv_domain, inv_pasid,
        inv_page, inv_span});

  task automatic results;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r);
    logic aw, w, b;
    b = 1'b0;
    @(posedge clock);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!b)
    begin
      @(negedge clock);
      aw = s_awready;
      w = s_wready;
      b = s_bvalid;
      `CHK(b ? s_bresp : r, r)
      @(posedge clock);
      if (aw)
        s_awvalid <= 1'b0;
      if (w)
        s_wvalid <= 1'b0;
    end
    s_bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r);
    logic ar, rv;
    rv = 1'b0;
    @(posedge clock);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    while (!rv)
    begin
      @(negedge clock);
      ar = s_arready;
      rv = s_rvalid;
      if (rv)
        `CHK({s_rresp, s_rdata}, {r, d})
      @(posedge clock);
      if (ar)
        s_arvalid <= 1'b0;
    end
    s_rready <= 1'b0;
  endtask : axr

  function automatic logic [127:0] mk(input logic [3:0] t,
    input logic [1:0] g, input logic [1:0] dr, input logic [15:0] d,
    input logic [19:0] p, input logic [63:0] hi);
    return {hi, 12'h000, p, d, 8'h00, dr, g, t};
  endfunction : mk

  task automatic cmd(input logic [127:0] c);
    logic dn;
    dn = 1'b0;
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_data <= c;
    while (!dn)
    begin
      @(negedge clock);
      dn = cmd_ready;
      @(posedge clock);
    end
    cmd_valid <= 1'b0;
    @(negedge clock);
  endtask : cmd

  task automatic op(input logic [4:0] t, input iofe_match_t m,
    input logic g, input logic [15:0] d, input logic [19:0] p,
    input logic [51:0] pg, input logic [5:0] s);
    do @(negedge clock);
    while (!drains_clear);
    if (q.size() == 0)
      q.push_back('x);
    `CHK(q.pop_front(), {t, m, g, d, p, pg, s})
  endtask : op

  initial
  begin
    #50000;
    failures++;
    results();
  end

  initial
  begin
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    axr(REG_CFG, 32'h0000_3010, RESP_OKAY);
    axr(REG_STAT, 32'h0000_0010, RESP_OKAY);
    axr(8'h10, 32'h0, RESP_SLVERR);
    axw(8'h10, 32'h0, RESP_SLVERR);
    axw(REG_STAT, 32'hffff_ffff, RESP_OKAY);
    axw(REG_CFG, 32'h0000_3008, RESP_OKAY);
    axr(REG_STAT, 32'h0000_0010, RESP_OKAY);
    cmd(mk(TYPE_SL_FLUSH, SL_GLOBAL, 2'b00, 16'h1234, P, HI0));
    op(TGT_ALL, MATCH_ALL, 1'b1, '0, '0, '0, '0);
    cmd(mk(TYPE_SL_FLUSH, SL_DOMAIN, 2'b10, 16'h1234, P, HI0));
    `CHK({rd_drain_req, wr_drain_req}, 2'b10)
    op(TGT_ALL, MATCH_DOM, 1'b1, D, '0, '0, '0);
    cmd(mk(TYPE_SL_FLUSH, SL_PAGE, 2'b01, 16'h1234, P, HI0));
    `CHK({rd_drain_req, wr_drain_req}, 2'b01)
    op(5'h05, MATCH_DOM_RANGE, 1'b1, D, '0, PG, 6'h09);
    op(5'h1a, MATCH_DOM, 1'b1, D, '0, '0, '0);
    cmd(mk(TYPE_SL_FLUSH, SL_PAGE, 2'b00, 16'h1234, P, HI1));
    op(5'h01, MATCH_DOM_RANGE, 1'b1, D, '0, PG, 6'h09);
    op(5'h1a, MATCH_DOM, 1'b1, D, '0, '0, '0);
    axw(REG_CFG, 32'h0001_3008, RESP_OKAY);
    slow <= 1'b1;
    cmd(mk(TYPE_SL_FLUSH, SL_GLOBAL, 2'b00, 16'h1234, P, HI0));
    `CHK({wbf_req, inv_valid}, 2'b10)
    op(TGT_ALL, MATCH_ALL, 1'b1, '0, '0, '0, '0);
    for (int g = 0; g < 4; g++)
    begin
      cmd(mk(TYPE_EXT_FLUSH, 2'(g), 2'b00, 16'h1234, P,
        g == 3 ? HI0 : HI3));
      `CHK({rd_drain_req, wr_drain_req}, 2'b11)
      case (g)
        0: op(5'h0a, MATCH_DOM, 1'b1, D, '0, '0, '0);
        1: op(5'h0a, MATCH_DOM, 1'b0, D, '0, '0, '0);
        2: op(5'h0a, MATCH_DOM_PASID, 1'b0, D, P, '0, '0);
        default:
        begin
          op(5'h02, MATCH_PASID_RANGE, 1'b0, D, P, PG, 6'h09);
          op(5'h08, MATCH_PASID_RANGE, 1'b1, D, P, PG, 6'h09);
        end
      endcase
    end
    slow <= 1'b0;
    cmd(mk(TYPE_EXT_FLUSH, EXT_PAGE, 2'b00, 16'h1234, P, HI3));
    op(5'h02, MATCH_PASID_RANGE, 1'b1, D, P, PG, 6'h09);
    cmd(mk(4'h3, SL_GLOBAL, 2'b11, 16'h1234, P, HI0));
    `CHK({cmd_err, rd_drain_req}, 2'b10)
    cmd(mk(TYPE_SL_FLUSH, 2'b00, 2'b00, 16'h1234, P, HI0));
    `CHK({cmd_err, cmd_ready}, 2'b11)
    repeat (4) @(negedge clock);
    `CHK(q.size(), 0)
    axr(REG_ERR, 32'h0000_0003, RESP_OKAY);
    axw(REG_ERR, 32'h0000_0003, RESP_OKAY);
    axr(REG_ERR, 32'h0000_0000, RESP_OKAY);
    axr(REG_CNT, 32'h0000_000a, RESP_OKAY);
    results();
  end
endmodule : testbench
bind iofe_flush_exec iofe_flush_exec_asserts chk_u (.*);
`default_nettype wire
